/* File: pkg/node_cfg_params.svh */
// Offsets, field positions, write masks and reset values of the node register bank
`ifndef NODE_CFG_PARAMS_SVH
`define NODE_CFG_PARAMS_SVH

`define OFF_IDENT      8'h00
`define OFF_TOPO       8'h01
`define OFF_LOCK_HDR   8'h04
`define OFF_NODE_ID    8'h05
`define OFF_PLL        8'h06
`define OFF_SW_DIV     8'h07
`define OFF_REF_DIV    8'h08
`define OFF_DIR_LO     8'h0c
`define OFF_DIR_HI     8'h0d
`define OFF_DBG_PIN    8'h10
`define OFF_DBG_SRC    8'h1f
`define OFF_LINK_STAT  8'h20
`define OFF_PLINK      8'h40
`define OFF_LINK_SETUP 8'h80
`define OFF_LINK_STAT2 8'ha0

`define BIT_GLOBAL_LOCK 31
`define BIT_PLL_LOCK    8
`define BIT_HDR_MODE    0

`define PLL_MASK     32'h039f_ff7f
`define SW_DIV_MASK  32'h0000_ffff
`define DBG_PIN_MASK 32'h0000_0003
`define DBG_SRC_MASK 32'h0000_0011
`define LOCK_MASK    32'h8000_0101
`define NODE_ID_MASK 32'h0000_ffff

`define RST_REF_DIV  32'h0000_0003
`define RST_PLL      32'h0000_0000

`endif

/* File: pkg/node_cfg_pkg.sv */
// Types shared by the node register bank
`default_nettype none
package node_cfg_pkg;
  typedef logic [31:0] word_t;   // One register word
  typedef logic [7:0]  addr_t;   // Register number
  typedef logic [15:0] node_id_t; // Routing identifier
endpackage
`default_nettype wire

/* File: src/switch_node_config_registers.sv */
// Configuration register bank of a switch node
`include "node_cfg_params.svh"
`default_nettype none

module switch_node_config_registers #(
  parameter logic [7:0] CHIP_ID     = 8'h5a, // Arbitrary value
  parameter logic [7:0] REVISION    = 8'h01, // Arbitrary value
  parameter logic [7:0] VERSION     = 8'h01, // Arbitrary value
  parameter logic [7:0] NUM_LINKS   = 8'h08,
  parameter logic [7:0] NUM_CORES   = 8'h01,
  parameter logic [7:0] LINKS_PER_P = 8'h04,
  parameter int         N_LINK      = 8,
  parameter int         N_PLINK     = 4
) (
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  input  wire logic                     cfg_wr,       // Config write strobe
  input  wire logic                     cfg_rd,       // Config read strobe
  input  wire node_cfg_pkg::addr_t      cfg_addr,
  input  wire node_cfg_pkg::word_t      cfg_wdata,
  input  wire logic                     boot_select_pin_zero,
  input  wire logic                     boot_select_pin_one,
  input  wire node_cfg_pkg::node_id_t   msg_dest,     // Incoming destination
  input  wire logic                     msg_valid,
  output var  node_cfg_pkg::word_t      cfg_rdata,
  output var  logic                     cfg_rvalid,
  output var  logic                     one_byte_headers,
  output var  node_cfg_pkg::node_id_t   node_id,
  output var  logic                     route_match,  // Destination is us
  output var  logic [4:0]               route_bit,    // MSB mismatch index
  output var  logic                     route_valid,
  output var  logic                     tile_reset    // One-cycle pulse
);

  // Stored registers. Every word is a row of flops; reserved bits are
  // masked off on the way in, so the read path needs no masking.
  // Link-side banks are flop arrays indexed by low address bits.
  // Lock and PLL words come first; banks follow.
  node_cfg_pkg::word_t lock_hdr;
  node_cfg_pkg::word_t pll;
  node_cfg_pkg::word_t sw_div;
  node_cfg_pkg::word_t ref_div;
  node_cfg_pkg::word_t dir_lo;
  node_cfg_pkg::word_t dir_hi;
  node_cfg_pkg::word_t dbg_pin;
  node_cfg_pkg::word_t dbg_src;
  node_cfg_pkg::word_t link_stat  [N_LINK];
  node_cfg_pkg::word_t plink      [N_PLINK];
  node_cfg_pkg::word_t link_setup [N_LINK];
  node_cfg_pkg::word_t link_stat2 [N_LINK];
  logic [1:0]          mode_pins;   // Captured after reset release
  logic                mode_taken;  // Capture done

  // Lock decode; the global lock wins over everything
  // A refused write is dropped without any answer on the bus, so
  // software must read back to learn whether a write landed. The
  // global lock also freezes the lock word itself until reset.
  wire logic global_lock = lock_hdr[`BIT_GLOBAL_LOCK];
  wire logic pll_lock    = lock_hdr[`BIT_PLL_LOCK];
  wire logic wr_ok       = cfg_wr & ~global_lock;

  // Per-register write selects
  // Each is one compare against a fixed number; the bank windows are
  // decoded apart below. Writes to 0x00, 0x01 and unmapped numbers
  // match nothing and so change nothing.
  wire logic wr_lock  = wr_ok & (cfg_addr == `OFF_LOCK_HDR);
  wire logic wr_id    = wr_ok & (cfg_addr == `OFF_NODE_ID);
  wire logic wr_pll   = wr_ok & ~pll_lock &
                        (cfg_addr == `OFF_PLL);
  wire logic wr_swdiv = wr_ok & (cfg_addr == `OFF_SW_DIV);
  wire logic wr_refdv = wr_ok & (cfg_addr == `OFF_REF_DIV);
  wire logic wr_dirlo = wr_ok & (cfg_addr == `OFF_DIR_LO);
  wire logic wr_dirhi = wr_ok & (cfg_addr == `OFF_DIR_HI);
  wire logic wr_dbgp  = wr_ok & (cfg_addr == `OFF_DBG_PIN);
  wire logic wr_dbgs  = wr_ok & (cfg_addr == `OFF_DBG_SRC);

  // Array window decode; index in the low bits
  // Windows sit on aligned numbers, so the high bits pick the bank
  // and the low bits index the entry with no adder in the path.
  // The bases are cut to the compared width on purpose.
  wire logic in_lstat  = cfg_addr[7:3] == 5'(`OFF_LINK_STAT >> 3);
  wire logic in_plink  = cfg_addr[7:2] == 6'(`OFF_PLINK >> 2);
  wire logic in_lsetup = cfg_addr[7:3] == 5'(`OFF_LINK_SETUP >> 3);
  wire logic in_lstat2 = cfg_addr[7:3] == 5'(`OFF_LINK_STAT2 >> 3);
  wire logic [2:0] idx8 = cfg_addr[2:0];
  wire logic [1:0] idx4 = cfg_addr[1:0];

  // Lock bits only ever latch on writes that pass the global lock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_hdr <= '0;
    end else if (wr_lock) begin
      // Both lock bits and the header bit stay writable here; only
      // the global lock keeps a later write from clearing them.
      // Every node must be given the same header bit by software.
      lock_hdr <= cfg_wdata & `LOCK_MASK;
    end
  end

  // Routing identifier; upper half stays zero
  // Only the low half is stored; the read side rebuilds the upper
  // half as zero, which saves sixteen flops that would hold nothing.
  // The identifier is also a port, so the routing logic below reads
  // the same flops that a configuration read returns.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      node_id <= '0;
    end else if (wr_id) begin
      node_id <= cfg_wdata[15:0];
    end
  end

  // PLL settings; an accepted write also pulses the tile reset
  // The pulse is registered so the tile sees a clean one-cycle
  // request, never a glitch from the address decode. A refused
  // write leaves both the word and the pulse untouched.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pll        <= `RST_PLL;
      tile_reset <= 1'b0;
    end else begin
      // Low by default, high only in the cycle after a write
      tile_reset <= wr_pll;
      if (wr_pll) begin
        pll <= cfg_wdata & `PLL_MASK;
      end
    end
  end

  // Divider, direction and debug registers
  // Both dividers keep only their low sixteen bits. The reference
  // divider resets to its working ratio so the node has a sane
  // reference clock before software touches it. The direction
  // tables are stored and read back only; steering by them is left
  // to the switch core outside this block.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_div  <= '0;
      ref_div <= `RST_REF_DIV;
      dir_lo  <= '0;
      dir_hi  <= '0;
      dbg_pin <= '0;
      dbg_src <= '0;
    end else begin
      if (wr_swdiv) sw_div  <= cfg_wdata & `SW_DIV_MASK;
      if (wr_refdv) ref_div <= cfg_wdata & `SW_DIV_MASK;
      if (wr_dirlo) dir_lo  <= cfg_wdata;
      if (wr_dirhi) dir_hi  <= cfg_wdata;
      if (wr_dbgp)  dbg_pin <= cfg_wdata & `DBG_PIN_MASK;
      if (wr_dbgs)  dbg_src <= cfg_wdata & `DBG_SRC_MASK;
    end
  end

  // Eight-entry link banks, one flip-flop word per entry
  // The index compare is shared by the three banks, whose windows
  // never overlap, so at most one entry takes any write.
  // Entries hold their value until an accepted write.
  for (genvar i = 0; i < N_LINK; i++) begin : g_link
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        link_stat[i]  <= '0;
        link_setup[i] <= '0;
        link_stat2[i] <= '0;
      end else if (wr_ok && idx8 == 3'(i)) begin
        if (in_lstat)  link_stat[i]  <= cfg_wdata;
        if (in_lsetup) link_setup[i] <= cfg_wdata;
        if (in_lstat2) link_stat2[i] <= cfg_wdata;
      end
    end
  end

  // Processor link bank
  // Four entries only; numbers 0x44 to 0x47 fall through and read
  // back as zero.
  for (genvar j = 0; j < N_PLINK; j++) begin : g_plink
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        plink[j] <= '0;
      end else if (wr_ok && in_plink && idx4 == 2'(j)) begin
        plink[j] <= cfg_wdata;
      end
    end
  end

  // Mode pins caught once, on the first edge after reset release
  // The pins are taken as synchronous. They are read once per reset, so a
  // later change on the board cannot alter the identity word until the next reset; a read
  // taken at that very first edge still shows zero in the pin field.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_pins  <= '0;
      mode_taken <= 1'b0;
    end else if (!mode_taken) begin
      mode_pins  <= {boot_select_pin_one, boot_select_pin_zero};
      mode_taken <= 1'b1;
    end
  end

  // Read multiplexer; unmapped numbers and reserved bits read zero
  // Banks are tested first because their windows cover many numbers;
  // the fixed registers follow in one flat case. A read has no side
  // effect, so a repeated read is harmless.
  node_cfg_pkg::word_t rd_mux;
  always_comb begin
    rd_mux = '0;
    if (in_lstat)       rd_mux = link_stat[idx8];
    else if (in_plink)  rd_mux = plink[idx4];
    else if (in_lsetup) rd_mux = link_setup[idx8];
    else if (in_lstat2) rd_mux = link_stat2[idx8];
    else begin
      // Fixed registers; unmapped numbers take the default
      unique case (cfg_addr)
        `OFF_IDENT:    rd_mux = {CHIP_ID, 6'h00, mode_pins,
                                 REVISION, VERSION};
        `OFF_TOPO:     rd_mux = {8'h00, NUM_LINKS, NUM_CORES,
                                 LINKS_PER_P};
        `OFF_LOCK_HDR: rd_mux = lock_hdr;
        `OFF_NODE_ID:  rd_mux = {16'h0000, node_id};
        `OFF_PLL:      rd_mux = pll;
        `OFF_SW_DIV:   rd_mux = sw_div;
        `OFF_REF_DIV:  rd_mux = ref_div;
        `OFF_DIR_LO:   rd_mux = dir_lo;
        `OFF_DIR_HI:   rd_mux = dir_hi;
        `OFF_DBG_PIN:  rd_mux = dbg_pin;
        `OFF_DBG_SRC:  rd_mux = dbg_src;
        default:       rd_mux = '0;
      endcase
    end
  end

  // Registered read answer, one cycle after the strobe
  // Data holds until the next read so a slow requester may pick it
  // up late; the valid flag stands for one cycle only. A write and
  // a read in the same cycle return the old word.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rdata  <= '0;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) cfg_rdata <= rd_mux;
    end
  end

  // Header mode reaches the switch core from a flop
  // One cycle behind the stored bit; the core should only change
  // header size between packets, so the delay does no harm.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      one_byte_headers <= 1'b0;
    end else begin
      one_byte_headers <= lock_hdr[`BIT_HDR_MODE];
    end
  end

  // Most significant mismatching bit, scanned from the bottom up
  // The loop runs upwards, so the last mismatching bit seen is the
  // highest one, which is what a top-down comparison finds first.
  // A full match leaves index zero; the match flag tells that case
  // apart from a mismatch in bit zero.
  wire node_cfg_pkg::node_id_t diff = msg_dest ^ node_id;
  logic [4:0] msb_idx;
  always_comb begin
    msb_idx = 5'h00;
    for (int b = 0; b < 16; b++) begin
      if (diff[b]) msb_idx = 5'(b);
    end
  end

  // Routing decision flops
  // Match and index hold until the next message; only the valid
  // flag is a pulse. Messages may come back to back.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      route_match <= 1'b0;
      route_bit   <= '0;
      route_valid <= 1'b0;
    end else begin
      route_valid <= msg_valid;
      if (msg_valid) begin
        // Decision taken only while a message is present
        route_match <= (diff == '0);
        route_bit   <= msb_idx;
      end
    end
  end

  // Limitation: a message that arrives in the cycle of an identifier
  // write is compared against the old identifier.
endmodule
`default_nettype wire

/* File: test/cfg_tile_model.sv */
// Tile model issuing configuration reads and writes
`default_nettype none
module cfg_tile_model (
  input  wire logic                clk,
  input  wire node_cfg_pkg::word_t cfg_rdata,
  output var  logic                cfg_wr,
  output var  logic                cfg_rd,
  output var  node_cfg_pkg::addr_t cfg_addr,
  output var  node_cfg_pkg::word_t cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = '0;
    cfg_wdata = '0;
  end
  // Write: strobe high across one rising edge
  task automatic wr(input node_cfg_pkg::addr_t a, node_cfg_pkg::word_t d);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 1'b0;
    cfg_wdata = ~d; // Released data shows no stale word
  endtask
  // Read: data answers in the cycle after the strobe edge
  task automatic rd(input node_cfg_pkg::addr_t a,
                    output node_cfg_pkg::word_t d);
    @(negedge clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge clk);
    cfg_rd = 1'b0;
    d = cfg_rdata;
  endtask
endmodule
`default_nettype wire

/* File: test/switch_node_config_registers_asserts.sv */
// Port checker of the node register bank
`default_nettype none
module switch_node_config_registers_asserts (
  input wire logic                   clk,
  input wire logic                   arst_n,
  input wire logic                   cfg_wr,
  input wire logic                   cfg_rd,
  input wire node_cfg_pkg::addr_t    cfg_addr,
  input wire node_cfg_pkg::word_t    cfg_wdata,
  input wire node_cfg_pkg::node_id_t msg_dest,
  input wire logic                   msg_valid,
  input wire logic                   cfg_rvalid,
  input wire logic                   one_byte_headers,
  input wire node_cfg_pkg::node_id_t node_id,
  input wire logic                   route_match,
  input wire logic [4:0]             route_bit,
  input wire logic                   tile_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic gl; // Global lock as seen from the bus
  logic pl; // PLL lock, follows each accepted lock write
  wire  w4 = cfg_wr && cfg_addr == 8'h04 && !gl; // Accepted lock write
  wire  w6 = cfg_wr && cfg_addr == 8'h06;        // Any PLL write
  // Track lock bits; global lock freezes both
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gl <= 1'b0;
      pl <= 1'b0;
    end else if (w4) begin
      gl <= cfg_wdata[31];
      pl <= cfg_wdata[8];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_rd; cfg_rvalid == $past(cfg_rd); endproperty
  property p_pll; w6 && !gl && !pl |=> tile_reset; endproperty
  property p_plock; w6 && (gl || pl) |=> !tile_reset; endproperty
  property p_hdr;
    w4 ##1 1 |=> one_byte_headers == $past(cfg_wdata[0], 2);
  endproperty
  property p_nid;
    cfg_wr && cfg_addr == 8'h05 && !gl |=> node_id == $past(cfg_wdata[15:0]);
  endproperty
  property p_glock; gl |=> $stable(node_id) && !tile_reset; endproperty
  property p_match;
    msg_valid |=> route_match == ($past(msg_dest) == $past(node_id));
  endproperty
  property p_msb;
    msg_valid && msg_dest[15] != node_id[15] |=> route_bit == 5'h0f;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  a_pll: assert property (p_pll) else $error("no tile reset");
  a_plock: assert property (p_plock) else $error("pll lock");
  a_hdr: assert property (p_hdr) else $error("header mode");
  a_nid: assert property (p_nid) else $error("node id");
  a_glock: assert property (p_glock) else $error("global lock");
  a_match: assert property (p_match) else $error("route match");
  a_msb: assert property (p_msb) else $error("msb first");
  c_rd: cover property (cfg_rvalid);
  c_trst: cover property (tile_reset);
  c_hit: cover property (route_match && msg_valid);
endmodule
bind switch_node_config_registers switch_node_config_registers_asserts chk (
  .clk, .arst_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .msg_dest,
  .msg_valid, .cfg_rvalid, .one_byte_headers, .node_id, .route_match,
  .route_bit, .tile_reset);
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench of the node register bank
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, cfg_wr, cfg_rd, cfg_rvalid, one_byte_headers;
  logic route_match, route_valid, tile_reset;
  logic arst_n = 1'b0, msg_valid = 1'b0;
  logic pin_zero = 1'b0, pin_one = 1'b1; // Mode pins, changed mid-run
  logic [4:0] route_bit;
  node_cfg_pkg::node_id_t msg_dest = '0, node_id;
  node_cfg_pkg::word_t cfg_rdata, cfg_wdata, d;
  node_cfg_pkg::addr_t cfg_addr;
  int n_fail = 0, n_tests = 0, cyc = 0;
  // Register number beside the word read after writing all ones
  logic [39:0] rows [20] = '{
    {8'h00,32'h5a020101}, {8'h01,32'h00080104}, {8'h02,32'h0},
    {8'h05,32'hffff}, {8'h06,32'h039fff7f}, {8'h07,32'hffff},
    {8'h08,32'hffff}, {8'h0c,32'hffffffff}, {8'h0d,32'hffffffff},
    {8'h10,32'h3}, {8'h1f,32'h11},
    {8'h20,32'hffffffff}, {8'h27,32'hffffffff}, {8'h40,32'hffffffff},
    {8'h43,32'hffffffff}, {8'h44,32'h0}, {8'h80,32'hffffffff},
    {8'h87,32'hffffffff}, {8'ha0,32'hffffffff}, {8'ha7,32'hffffffff}};
  switch_node_config_registers DUT (.clk, .arst_n, .cfg_wr, .cfg_rd,
    .cfg_addr, .cfg_wdata, .boot_select_pin_zero(pin_zero),
    .boot_select_pin_one(pin_one), .msg_dest, .msg_valid, .cfg_rdata,
    .cfg_rvalid, .one_byte_headers, .node_id, .route_match, .route_bit,
    .route_valid, .tile_reset);
  cfg_tile_model tile (.clk, .cfg_rdata, .cfg_wr, .cfg_rd, .cfg_addr,
    .cfg_wdata);
  // 100 MHz clock and a hang limit
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict;
    end
  end
  task automatic chk_w(input node_cfg_pkg::word_t g, e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_f(input logic g, e);
    chk_w({31'h0, g}, {31'h0, e});
  endtask
  // One message in, route answer one cycle later
  task automatic msg(input node_cfg_pkg::node_id_t t, logic m, logic [4:0] b);
    @(negedge clk);
    msg_valid = 1'b1;
    msg_dest = t;
    @(negedge clk);
    msg_valid = 1'b0;
    msg_dest = ~t;
    chk_f(route_valid, 1'b1);
    chk_f(route_match, m);
    chk_w({27'h0, route_bit}, {27'h0, b});
  endtask
  task automatic give_verdict;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    foreach (rows[i]) begin
      tile.wr(rows[i][39:32], 32'hffffffff);
      tile.rd(rows[i][39:32], d);
      chk_w(d, rows[i][31:0]); // 13
      chk_f(cfg_rvalid, 1'b1);
    end
    tile.wr(8'h05, 32'h1234);
    chk_w({16'h0000, node_id}, 32'h0000_1234);
    msg(16'h1234, 1'b1, 5'h00);
    msg(16'h9234, 1'b0, 5'h0f);
    msg(16'h1236, 1'b0, 5'h01);
    tile.wr(8'h04, 32'h1); // Same header mode as all nodes
    @(negedge clk);
    chk_f(one_byte_headers, 1'b1);
    tile.wr(8'h06, 32'h0000_0155);
    chk_f(tile_reset, 1'b1);
    tile.wr(8'h04, 32'h101);
    tile.wr(8'h06, 32'h0);
    chk_f(tile_reset, 1'b0);
    tile.rd(8'h06, d);
    chk_w(d, 32'h0000_0155);
    tile.wr(8'h05, 32'h42);
    tile.wr(8'h04, 32'h80000101);
    tile.wr(8'h05, 32'h7777);
    tile.wr(8'h04, 32'h0);
    tile.rd(8'h05, d);
    chk_w(d, 32'h42);
    tile.rd(8'h04, d);
    chk_w(d, 32'h80000101);
    arst_n = 1'b0;
    pin_zero = 1'b1;
    pin_one = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    tile.rd(8'h00, d);
    chk_w(d, 32'h5a010101);
    tile.rd(8'h05, d);
    chk_w(d, 32'h0);
    tile.rd(8'h08, d);
    chk_w(d, 32'h3); // Reference divider reset value
    chk_f(one_byte_headers, 1'b0);
    give_verdict;
  end
endmodule
`default_nettype wire
